/* File: rtl/uncore_evsel_pkg.sv */
// Constants and types for the uncore cache and home event selector
package uncore_evsel_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 32;
  localparam int TRK_NUM = 3;
  localparam int TRK_ENTRIES = 8;
  localparam int OCC_W = 4;
  localparam int TRK_IOH = 0;
  localparam int TRK_REM = 1;
  localparam int TRK_LOC = 2;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam int CTRL_EVT_LSB = 0;
  localparam int CTRL_UMASK_LSB = 8;
  localparam int CTRL_EN_BIT = 16;
  localparam int STAT_WBMISS_BIT = 0;
  localparam int STAT_BADM_BIT = 1;
  localparam int STAT_W = 2;
  localparam logic [7:0] EVT_RESET = 8'h00;
  localparam logic [7:0] UMASK_RESET = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_RESET = 32'h00000000;

  localparam logic [7:0] EV_LLC_HIT = 8'h08;
  localparam logic [7:0] EV_LLC_MISS = 8'h09;
  localparam logic [7:0] EV_LLC_FILL = 8'h0A;
  localparam logic [7:0] EV_LLC_VICTIM = 8'h0B;
  localparam logic [7:0] EV_HOME_REQ = 8'h20;
  localparam logic [7:0] EV_TRK_FULL = 8'h21;
  localparam logic [7:0] EV_TRK_BUSY = 8'h22;
  localparam logic [7:0] EV_TRK_OCC = 8'h23;

  localparam logic [7:0] UM_READ = 8'h01;
  localparam logic [7:0] UM_WRITE = 8'h02;
  localparam logic [7:0] UM_SNOOP = 8'h04;
  localparam logic [7:0] UM_RW = 8'h03;
  localparam logic [7:0] UM_FILL_ANY = 8'h0F;
  localparam logic [7:0] UM_VICT_ANY = 8'h1F;
  localparam logic [7:0] UM_LOCAL_RD = 8'h10;
  localparam logic [7:0] UM_TRK_IOH = 8'h01;
  localparam logic [7:0] UM_TRK_REM = 8'h02;
  localparam logic [7:0] UM_TRK_LOC = 8'h04;
  localparam int HIT_BITS = 3;
  localparam int FILL_BITS = 4;
  localparam int VICT_BITS = 5;
  localparam int REQ_BITS = 6;

  typedef enum logic [1:0] {
    REQ_READ = 2'b00,
    REQ_WRITEBACK = 2'b01,
    REQ_SNOOP = 2'b10
  } llc_req_t;

  typedef enum logic [2:0] {
    ST_M = 3'b000,
    ST_E = 3'b001,
    ST_S = 3'b010,
    ST_I = 3'b011,
    ST_F = 3'b100
  } line_state_t;

  typedef enum logic [1:0] {
    SRC_IO_HUB = 2'b00,
    SRC_REMOTE = 2'b01,
    SRC_LOCAL = 2'b10
  } home_src_t;
endpackage : uncore_evsel_pkg

/* File: rtl/trk_stat_if.sv */
// Tracker summary carried from the tracker monitor to the selector
interface trk_stat_if;
  import uncore_evsel_pkg::*;
  logic [TRK_NUM-1:0] full;
  logic [TRK_NUM-1:0] busy;
  logic [TRK_NUM-1:0][OCC_W-1:0] rd_occ;
  modport src (output full, busy, rd_occ);
  modport dst (input full, busy, rd_occ);
endinterface : trk_stat_if

/* File: rtl/tracker_monitor.sv */
// Registered full, busy and read occupancy of each home tracker
module tracker_monitor
  import uncore_evsel_pkg::*;
(
  input wire logic pclk, // Uncore clock
  input wire logic presetn, // Async reset, active low
  input wire logic [TRK_NUM*TRK_ENTRIES-1:0] trk_valid, // Entry valid
  input wire logic [TRK_NUM*TRK_ENTRIES-1:0] trk_read, // Entry is a read
  trk_stat_if.src stat // Summary out
);
  wire logic [TRK_NUM-1:0] next_full;
  wire logic [TRK_NUM-1:0] next_busy;
  wire logic [TRK_NUM-1:0][OCC_W-1:0] next_occ;

  for (genvar t = 0; t < TRK_NUM; t++) begin : g_trk
    wire logic [TRK_ENTRIES-1:0] v = trk_valid[t*TRK_ENTRIES +: TRK_ENTRIES];
    wire logic [TRK_ENTRIES-1:0] r = trk_read[t*TRK_ENTRIES +: TRK_ENTRIES];
    assign next_full[t] = &v;
    assign next_busy[t] = |v;
    // Only valid read entries add to occupancy
    assign next_occ[t] = OCC_W'($countones(v & r));
  end

  // One register stage keeps the wide reduction off the counter adder path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat.full <= '0;
      stat.busy <= '0;
      stat.rd_occ <= '0;
    end else begin
      stat.full <= next_full;
      stat.busy <= next_busy;
      stat.rd_occ <= next_occ;
    end
  end
endmodule : tracker_monitor

/* File: rtl/uncore_llc_home_event_select.sv */
// Cache and home tracker event selector with APB counter registers

// Notes on behaviour
// [RULE1] Code 08H mask 02H counts writeback requests hitting the cache.
// [RULE2] Code 08H mask 04H counts hub or remote snoops hitting the cache.
// [RULE3] Code 08H mask 03H counts read or writeback requests that hit.
// [RULE4] Code 09H mask 01H counts code, data and ownership reads that miss.
// [RULE5] Code 09H mask 02H counts writeback misses, expected to stay zero.
// [RULE6] Code 09H mask 04H counts hub or remote snoops missing the cache.
// [RULE7] Code 09H mask 03H counts read or writeback requests that miss.
// [RULE8] Fill event counts fills by new state; 0FH counts any state.
// [RULE9] A modified fill is legal only for a forwarded read-invalidate-own.
// [RULE10] Code 0BH counts victims by prior state; 1FH counts any state.
// [RULE11] A modified victim is written back to its local or remote home.
// [RULE12] Code 20H counts home requests by source and read or write.
// [RULE13] Code 21H counts cycles the chosen tracker has every entry full.
// [RULE14] Code 22H counts cycles the chosen tracker holds any entry.
// [RULE15] Code 23H accumulates read occupancy of the chosen tracker.
// [RULE16] Occupancy adds the valid read entries held each cycle.
// [RULE17] An undefined code and mask pair leaves the counter unchanged.
module uncore_llc_home_event_select
  import uncore_evsel_pkg::*;
(
  input wire logic pclk, // Uncore clock, 200 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [DATA_W-1:0] pwdata, // APB write data
  output logic [DATA_W-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic llc_req_valid, // Cache lookup done this cycle
  input wire llc_req_t llc_req_type, // Lookup kind
  input wire logic llc_req_hit, // Lookup hit
  input wire logic llc_fill_valid, // Line allocated this cycle
  input wire line_state_t llc_fill_state, // New line state
  input wire logic llc_fill_fwd_rio, // Fill forwarded for read-inv-own
  input wire logic llc_victim_valid, // Line victimized this cycle
  input wire line_state_t llc_victim_state, // Prior victim state
  input wire logic llc_victim_home_remote, // Victim home is remote
  input wire logic home_req_valid, // Home logic request accepted
  input wire home_src_t home_req_src, // Request source
  input wire logic home_req_write, // Request is a write
  input wire logic [TRK_NUM*TRK_ENTRIES-1:0] trk_valid, // Entry valid
  input wire logic [TRK_NUM*TRK_ENTRIES-1:0] trk_read, // Entry is a read
  output logic victim_wb_valid, // Writeback of modified victim
  output logic victim_wb_remote // That writeback goes to a remote home
);
  logic [7:0] evt_code;
  logic [7:0] umask;
  logic cnt_en;
  logic [CNT_W-1:0] count;
  logic [STAT_W-1:0] status;
  logic [OCC_W-1:0] inc;
  logic setup;
  logic wr_acc;
  logic addr_hit;
  logic count_wr;
  logic counting;
  logic [DATA_W-1:0] ctrl_word;
  logic [HIT_BITS-1:0] hit_vec;
  logic [HIT_BITS-1:0] miss_vec;
  logic [FILL_BITS-1:0] fill_vec;
  logic [VICT_BITS-1:0] vict_vec;
  logic [REQ_BITS-1:0] req_vec;
  logic [STAT_W-1:0] stat_set;
  logic [STAT_W-1:0] stat_clr;
  logic trk_ok;
  logic [1:0] trk_idx;
  logic bad_m_fill;
  logic wb_miss;

  trk_stat_if trk_stat ();

  tracker_monitor u_trk (
    .pclk,
    .presetn,
    .trk_valid,
    .trk_read,
    .stat (trk_stat.src)
  );

  // Mask is usable when nonzero and no bit lies above the event's width
  function automatic logic mask_ok(input logic [7:0] m, input int n);
    return (m != 8'h00) && ((m >> n) == 8'h00);
  endfunction : mask_ok

  // APB decode; zero wait states, read data captured in the setup cycle
  assign setup = psel && !penable;
  assign addr_hit = (paddr == OFS_CTRL) || (paddr == OFS_COUNT) ||
                    (paddr == OFS_STATUS);
  assign wr_acc = psel && penable && pwrite && addr_hit;
  assign count_wr = wr_acc && (paddr == OFS_COUNT);
  assign counting = cnt_en && !count_wr;
  assign pready = 1'b1;
  assign ctrl_word = {15'h0000, cnt_en, umask, evt_code};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_code <= EVT_RESET;
      umask <= UMASK_RESET;
      cnt_en <= 1'b0;
    end else if (wr_acc && paddr == OFS_CTRL) begin
      evt_code <= pwdata[CTRL_EVT_LSB +: 8];
      umask <= pwdata[CTRL_UMASK_LSB +: 8];
      cnt_en <= pwdata[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !addr_hit;
      case (paddr)
        OFS_CTRL: prdata <= ctrl_word;
        OFS_COUNT: prdata <= count;
        OFS_STATUS: prdata <= DATA_W'(status);
        default: prdata <= '0;
      endcase
    end
  end

  // Condition vectors, bit order matching the unit mask encodings
  always_comb begin
    hit_vec[0] = llc_req_valid && llc_req_type == REQ_READ && llc_req_hit;
    hit_vec[1] = llc_req_valid && llc_req_type == REQ_WRITEBACK &&
                 llc_req_hit; // [RULE1]
    hit_vec[2] = llc_req_valid && llc_req_type == REQ_SNOOP &&
                 llc_req_hit; // [RULE2]
    miss_vec[0] = llc_req_valid && llc_req_type == REQ_READ &&
                  !llc_req_hit; // [RULE4]
    miss_vec[1] = wb_miss; // [RULE5]
    miss_vec[2] = llc_req_valid && llc_req_type == REQ_SNOOP &&
                  !llc_req_hit; // [RULE6]
  end

  assign wb_miss = llc_req_valid && llc_req_type == REQ_WRITEBACK &&
                   !llc_req_hit;

  // A modified fill without the forwarded read-invalidate-own cause is
  // not an allocation in modified state; it is flagged instead
  assign bad_m_fill = llc_fill_valid && llc_fill_state == ST_M &&
                      !llc_fill_fwd_rio; // [RULE9]

  always_comb begin
    fill_vec[0] = llc_fill_valid && llc_fill_state == ST_M &&
                  llc_fill_fwd_rio; // [RULE9]
    fill_vec[1] = llc_fill_valid && llc_fill_state == ST_E;
    fill_vec[2] = llc_fill_valid && llc_fill_state == ST_S;
    fill_vec[3] = llc_fill_valid && llc_fill_state == ST_F;
    vict_vec[0] = llc_victim_valid && llc_victim_state == ST_M;
    vict_vec[1] = llc_victim_valid && llc_victim_state == ST_E;
    vict_vec[2] = llc_victim_valid && llc_victim_state == ST_S;
    vict_vec[3] = llc_victim_valid && llc_victim_state == ST_I;
    vict_vec[4] = llc_victim_valid && llc_victim_state == ST_F;
  end

  // Source and direction pick one of six bits; an unused source code
  // shifts the bit out and counts nothing
  assign req_vec = REQ_BITS'(home_req_valid) <<
                   {home_req_src, home_req_write}; // [RULE12]

  always_comb begin
    trk_ok = 1'b1;
    trk_idx = 2'(TRK_IOH);
    case (umask)
      UM_TRK_IOH: trk_idx = 2'(TRK_IOH);
      UM_TRK_REM: trk_idx = 2'(TRK_REM);
      UM_TRK_LOC: trk_idx = 2'(TRK_LOC);
      default: trk_ok = 1'b0;
    endcase
  end

  always_comb begin
    inc = '0;
    case (evt_code)
      EV_LLC_HIT: begin
        if (mask_ok(umask, HIT_BITS)) begin
          inc = OCC_W'(|(umask[HIT_BITS-1:0] & hit_vec)); // [RULE3]
        end
      end
      EV_LLC_MISS: begin
        if (mask_ok(umask, HIT_BITS)) begin
          inc = OCC_W'(|(umask[HIT_BITS-1:0] & miss_vec)); // [RULE7]
        end
      end
      EV_LLC_FILL: begin
        if (mask_ok(umask, FILL_BITS)) begin
          inc = OCC_W'(|(umask[FILL_BITS-1:0] & fill_vec)); // [RULE8]
        end
      end
      EV_LLC_VICTIM: begin
        if (mask_ok(umask, VICT_BITS)) begin
          inc = OCC_W'(|(umask[VICT_BITS-1:0] & vict_vec)); // [RULE10]
        end
      end
      EV_HOME_REQ: begin
        if (mask_ok(umask, REQ_BITS)) begin
          inc = OCC_W'(|(umask[REQ_BITS-1:0] & req_vec)); // [RULE12]
        end
      end
      EV_TRK_FULL: begin
        if (trk_ok) begin
          inc = OCC_W'(trk_stat.full[trk_idx]); // [RULE13]
        end
      end
      EV_TRK_BUSY: begin
        if (trk_ok) begin
          inc = OCC_W'(trk_stat.busy[trk_idx]); // [RULE14]
        end
      end
      EV_TRK_OCC: begin
        if (trk_ok) begin
          inc = trk_stat.rd_occ[trk_idx]; // [RULE15] [RULE16]
        end
      end
      default: inc = '0; // [RULE17]
    endcase
  end

  // A software write to the counter wins over an increment in that cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= COUNT_RESET;
    end else if (count_wr) begin
      count <= pwdata;
    end else if (cnt_en) begin
      count <= count + CNT_W'(inc);
    end
  end

  // Sticky anomaly flags, write one to clear, a new event beats the clear
  always_comb begin
    stat_set = '0;
    stat_set[STAT_WBMISS_BIT] = wb_miss; // [RULE5]
    stat_set[STAT_BADM_BIT] = bad_m_fill; // [RULE9]
    stat_clr = '0;
    if (wr_acc && paddr == OFS_STATUS) begin
      stat_clr = pwdata[STAT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status <= (status & ~stat_clr) | stat_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      victim_wb_valid <= 1'b0;
      victim_wb_remote <= 1'b0;
    end else begin
      victim_wb_valid <= vict_vec[0]; // [RULE11]
      victim_wb_remote <= vict_vec[0] && llc_victim_home_remote;
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic logic sel(input logic [7:0] e, input logic [7:0] m);
    return counting && evt_code == e && umask == m;
  endfunction : sel

  sequence s_bump1;
    count == $past(count) + 32'h00000001;
  endsequence

  sequence s_hold;
    count == $past(count);
  endsequence

  a_hit_write: assert property ( // [RULE1]
    sel(EV_LLC_HIT, UM_WRITE) && llc_req_valid &&
    llc_req_type == REQ_WRITEBACK && llc_req_hit |=> s_bump1)
    else $error("writeback hit not counted");
  a_hit_snoop: assert property ( // [RULE2]
    sel(EV_LLC_HIT, UM_SNOOP) && llc_req_valid &&
    llc_req_type == REQ_SNOOP && llc_req_hit |=> s_bump1)
    else $error("snoop hit not counted");
  a_hit_any: assert property ( // [RULE3]
    sel(EV_LLC_HIT, UM_RW) && llc_req_valid && llc_req_hit &&
    llc_req_type != REQ_SNOOP |=> s_bump1)
    else $error("read or write hit not counted");
  a_miss_read: assert property ( // [RULE4]
    sel(EV_LLC_MISS, UM_READ) && llc_req_valid &&
    llc_req_type == REQ_READ && !llc_req_hit |=> s_bump1)
    else $error("read miss not counted");
  a_miss_write: assert property ( // [RULE5]
    sel(EV_LLC_MISS, UM_WRITE) && wb_miss |=> s_bump1 ##0
    status[STAT_WBMISS_BIT])
    else $error("writeback miss not counted or flagged");
  a_miss_snoop: assert property ( // [RULE6]
    sel(EV_LLC_MISS, UM_SNOOP) && !(llc_req_valid &&
    llc_req_type == REQ_SNOOP && !llc_req_hit) |=> s_hold)
    else $error("snoop miss counted without cause");
  a_miss_any: assert property ( // [RULE7]
    sel(EV_LLC_MISS, UM_RW) && llc_req_valid && !llc_req_hit &&
    llc_req_type != REQ_SNOOP |=> s_bump1)
    else $error("read or write miss not counted");
  a_fill_any: assert property ( // [RULE8]
    sel(EV_LLC_FILL, UM_FILL_ANY) && llc_fill_valid && !bad_m_fill
    |=> s_bump1)
    else $error("fill not counted");
  a_fill_m_cause: assert property ( // [RULE9]
    sel(EV_LLC_FILL, UM_READ) && bad_m_fill |=> s_hold ##0
    status[STAT_BADM_BIT])
    else $error("unqualified modified fill counted");
  a_victim_any: assert property ( // [RULE10]
    sel(EV_LLC_VICTIM, UM_VICT_ANY) && llc_victim_valid |=> s_bump1)
    else $error("victim not counted");
  a_victim_wb: assert property ( // [RULE11]
    llc_victim_valid && llc_victim_state == ST_M |=> victim_wb_valid &&
    victim_wb_remote == $past(llc_victim_home_remote))
    else $error("modified victim not written back");
  a_home_local_rd: assert property ( // [RULE12]
    sel(EV_HOME_REQ, UM_LOCAL_RD) && home_req_valid &&
    home_req_src == SRC_LOCAL && !home_req_write |=> s_bump1)
    else $error("local read request not counted");

  sequence s_ioh_full;
    (&trk_valid[TRK_IOH*TRK_ENTRIES +: TRK_ENTRIES]) ##1
    sel(EV_TRK_FULL, UM_TRK_IOH);
  endsequence

  sequence s_rem_busy;
    (|trk_valid[TRK_REM*TRK_ENTRIES +: TRK_ENTRIES]) ##1
    sel(EV_TRK_BUSY, UM_TRK_REM);
  endsequence

  sequence s_loc_all_reads;
    (&(trk_valid[TRK_LOC*TRK_ENTRIES +: TRK_ENTRIES] &
    trk_read[TRK_LOC*TRK_ENTRIES +: TRK_ENTRIES])) ##1
    sel(EV_TRK_OCC, UM_TRK_LOC);
  endsequence

  a_trk_full: assert property ( // [RULE13]
    s_ioh_full |=> s_bump1)
    else $error("full tracker cycle not counted");
  a_trk_busy: assert property ( // [RULE14]
    s_rem_busy |=> s_bump1)
    else $error("busy tracker cycle not counted");
  a_trk_occ: assert property ( // [RULE15] [RULE16]
    s_loc_all_reads |=> count == $past(count) + 32'h00000008)
    else $error("read occupancy not accumulated");
  a_undef_pair: assert property ( // [RULE17]
    counting && umask == 8'h00 |=> s_hold)
    else $error("undefined selection changed the counter");
endmodule : uncore_llc_home_event_select

/* File: sim/llc_home_model.sv */
// Behavioural cache and home tracker pipeline feeding the event selector
module llc_home_model
  import uncore_evsel_pkg::*;
(
  input wire logic pclk, // Uncore clock
  output logic llc_req_valid, // Lookup pulse
  output llc_req_t llc_req_type, // Lookup kind
  output logic llc_req_hit, // Lookup hit
  output logic llc_fill_valid, // Fill pulse
  output line_state_t llc_fill_state, // New line state
  output logic llc_fill_fwd_rio, // Fill forwarded for read-inv-own
  output logic llc_victim_valid, // Victim pulse
  output line_state_t llc_victim_state, // Prior line state
  output logic llc_victim_home_remote, // Victim home is remote
  output logic home_req_valid, // Home request pulse
  output home_src_t home_req_src, // Request source
  output logic home_req_write, // Request is a write
  output logic [TRK_NUM*TRK_ENTRIES-1:0] trk_valid, // Entry valid
  output logic [TRK_NUM*TRK_ENTRIES-1:0] trk_read // Entry is a read
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {llc_req_valid, llc_fill_valid, llc_victim_valid, home_req_valid} = '0;
    {llc_req_hit, llc_fill_fwd_rio, llc_victim_home_remote} = '0;
    home_req_write = 1'b0;
    llc_req_type = REQ_READ;
    llc_fill_state = ST_I;
    llc_victim_state = ST_I;
    home_req_src = SRC_LOCAL;
    trk_valid = '0;
    trk_read = '0;
  end

  // Writebacks are only ever sent as hits, the cache being inclusive
  // Idle fields show the inverse so stale values never pass for data
  task automatic lookup(input llc_req_t kind, input logic hit);
    @(posedge pclk);
    llc_req_valid <= 1'b1;
    llc_req_type <= kind;
    llc_req_hit <= hit;
    @(posedge pclk);
    llc_req_valid <= 1'b0;
    llc_req_type <= llc_req_t'(~kind);
    llc_req_hit <= ~hit;
  endtask : lookup

  // Modified fills carry fwd_rio unless a scenario asks otherwise
  task automatic fill(input line_state_t st, input logic fwd);
    @(posedge pclk);
    llc_fill_valid <= 1'b1;
    llc_fill_state <= st;
    llc_fill_fwd_rio <= fwd;
    @(posedge pclk);
    llc_fill_valid <= 1'b0;
    llc_fill_state <= line_state_t'(~st);
    llc_fill_fwd_rio <= ~fwd;
  endtask : fill

  task automatic victim(input line_state_t st, input logic remote);
    @(posedge pclk);
    llc_victim_valid <= 1'b1;
    llc_victim_state <= st;
    llc_victim_home_remote <= remote;
    @(posedge pclk);
    llc_victim_valid <= 1'b0;
    llc_victim_state <= line_state_t'(~st);
    llc_victim_home_remote <= ~remote;
  endtask : victim

  task automatic home(input home_src_t src, input logic wr);
    @(posedge pclk);
    home_req_valid <= 1'b1;
    home_req_src <= src;
    home_req_write <= wr;
    @(posedge pclk);
    home_req_valid <= 1'b0;
    home_req_src <= home_src_t'(~src);
    home_req_write <= ~wr;
  endtask : home

  task automatic set_trk(input logic [23:0] v, input logic [23:0] r);
    @(posedge pclk);
    trk_valid <= v;
    trk_read <= r;
  endtask : set_trk
endmodule : llc_home_model

/* File: sim/uncore_llc_home_event_select_bench.sv */
// Self-checking bench for the cache and home tracker event selector
module uncore_llc_home_event_select_bench
  import uncore_evsel_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata, rd_data;
  logic pready, pslverr, rd_err;
  logic llc_req_valid, llc_req_hit, llc_fill_valid, llc_fill_fwd_rio;
  logic llc_victim_valid, llc_victim_home_remote, home_req_valid;
  logic home_req_write, victim_wb_valid, victim_wb_remote;
  llc_req_t llc_req_type;
  line_state_t llc_fill_state, llc_victim_state;
  home_src_t home_req_src;
  logic [TRK_NUM*TRK_ENTRIES-1:0] trk_valid, trk_read;
  int bad_count = 0;
  int checked = 0;

  always #2.5 pclk = ~pclk;

  uncore_llc_home_event_select uncore_llc_home_event_select_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .llc_req_valid, .llc_req_type, .llc_req_hit,
    .llc_fill_valid, .llc_fill_state, .llc_fill_fwd_rio, .llc_victim_valid,
    .llc_victim_state, .llc_victim_home_remote, .home_req_valid,
    .home_req_src, .home_req_write, .trk_valid, .trk_read, .victim_wb_valid,
    .victim_wb_remote);

  llc_home_model llc_home_model_i (
    .pclk, .llc_req_valid, .llc_req_type, .llc_req_hit, .llc_fill_valid,
    .llc_fill_state, .llc_fill_fwd_rio, .llc_victim_valid, .llc_victim_state,
    .llc_victim_home_remote, .home_req_valid, .home_req_src, .home_req_write,
    .trk_valid, .trk_read);

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic fail(input string msg);
    bad_count++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
    checked++;
    if (got !== exp) begin
      fail($sformatf("%s got %h want %h", msg, got, exp));
    end
  endtask : check_val

  // Read data and error are taken at the edge that sees pready high
  task automatic apb_xfer(input logic wr, input logic [7:0] addr,
      input logic [31:0] wdata);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail("no pready");
      final_report();
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic rd(input logic [7:0] addr);
    apb_xfer(1'b0, addr, '0);
  endtask : rd

  task automatic select(input logic [7:0] code, input logic [7:0] mask);
    apb_xfer(1'b1, OFS_CTRL, {15'h0000, 1'b1, mask, code});
    apb_xfer(1'b1, OFS_COUNT, 32'h00000000);
  endtask : select

  task automatic check_count(input logic [31:0] exp, input string msg);
    repeat (3) @(posedge pclk);
    rd(OFS_COUNT);
    check_val(rd_data, exp, msg);
  endtask : check_count

  // Lookups per kind: hits read 1, writeback 2, snoop 3; misses 2, 0, 1
  task automatic send_lookups();
    for (int k = 0; k < 3; k++) begin
      repeat (k + 1) llc_home_model_i.lookup(llc_req_t'(k), 1'b1);
    end
    repeat (2) llc_home_model_i.lookup(REQ_READ, 1'b0);
    llc_home_model_i.lookup(REQ_SNOOP, 1'b0);
  endtask : send_lookups

  // Chosen tracker full 4 cycles with 3 reads, then 5 entries held 3 cycles with 2 reads
  task automatic trk_pattern(input int t);
    logic [23:0] v, r;
    v = 24'h010101;
    r = 24'h010101;
    v[t*8+:8] = 8'hFF;
    r[t*8+:8] = 8'h07;
    llc_home_model_i.set_trk(v, r);
    repeat (3) @(posedge pclk);
    v[t*8+:8] = 8'h1F;
    r[t*8+:8] = 8'h03;
    llc_home_model_i.set_trk(v, r);
    repeat (2) @(posedge pclk);
    llc_home_model_i.set_trk(24'h000000, 24'h000000);
  endtask : trk_pattern

  task automatic t_reset();
    rd(OFS_CTRL);
    check_val(rd_data, 32'h00000000, "ctrl reset");
    rd(OFS_COUNT);
    check_val(rd_data, COUNT_RESET, "count reset");
    rd(8'h0C);
    check_val({rd_data[30:0], rd_err}, 32'h00000001, "unmapped read");
    $display("test reset done");
  endtask : t_reset

  task automatic t_hit_miss();
    logic [7:0] masks [4] = '{8'h01, 8'h02, 8'h04, 8'h03};
    int miss_n [3] = '{2, 0, 1};
    int eh, em;
    for (int m = 0; m < 4; m++) begin
      eh = 0;
      em = 0;
      for (int k = 0; k < 3; k++) begin
        if (masks[m][k]) begin
          eh += k + 1;
          em += miss_n[k];
        end
      end
      select(EV_LLC_HIT, masks[m]);
      send_lookups();
      check_count(eh, "hit count");
      select(EV_LLC_MISS, masks[m]);
      send_lookups();
      check_count(em, "miss count");
    end
    rd(OFS_STATUS);
    check_val(rd_data, 32'h00000000, "no writeback miss");
    $display("test hit and miss done");
  endtask : t_hit_miss

  task automatic t_fill();
    logic [7:0] masks [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0F};
    line_state_t st [4] = '{ST_M, ST_E, ST_S, ST_F};
    int e;
    for (int m = 0; m < 5; m++) begin
      e = 0;
      select(EV_LLC_FILL, masks[m]);
      for (int j = 0; j < 4; j++) begin
        if (masks[m][j]) e += j + 1;
        repeat (j + 1) llc_home_model_i.fill(st[j], 1'b1);
      end
      llc_home_model_i.fill(ST_M, 1'b0);
      check_count(e, "fill count");
    end
    rd(OFS_STATUS);
    check_val(rd_data & 32'h2, 32'h2, "bad modified fill");
    apb_xfer(1'b1, OFS_STATUS, 32'h00000002);
    rd(OFS_STATUS);
    check_val(rd_data, 32'h00000000, "status cleared");
    $display("test fill done");
  endtask : t_fill

  task automatic t_victim();
    logic [7:0] masks [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h1F};
    int e;
    for (int m = 0; m < 6; m++) begin
      e = 0;
      select(EV_LLC_VICTIM, masks[m]);
      for (int j = 0; j < 5; j++) begin
        if (masks[m][j]) e += j + 2;
        for (int n = 0; n < j + 2; n++) begin
          llc_home_model_i.victim(line_state_t'(j), n[0]);
          #1;
          check_val(victim_wb_valid, j == 0, "wb pulse");
          check_val(victim_wb_remote, j == 0 && n[0], "wb home");
        end
      end
      check_count(e, "victim count");
    end
    $display("test victim done");
  endtask : t_victim

  task automatic t_home();
    logic [7:0] masks [7];
    int e;
    masks = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h3F};
    for (int m = 0; m < 7; m++) begin
      e = 0;
      select(EV_HOME_REQ, masks[m]);
      for (int j = 0; j < 6; j++) begin
        if (masks[m][j]) e += j + 1;
        repeat (j + 1) llc_home_model_i.home(home_src_t'(j / 2), j[0]);
      end
      llc_home_model_i.home(home_src_t'(2'b11), 1'b0);
      check_count(e, "home requests");
    end
    $display("test home done");
  endtask : t_home

  task automatic t_tracker();
    for (int t = 0; t < 3; t++) begin
      select(EV_TRK_FULL, 8'h01 << t);
      trk_pattern(t);
      check_count(4, "full cycles");
      select(EV_TRK_BUSY, 8'h01 << t);
      trk_pattern(t);
      check_count(7, "busy cycles");
      select(EV_TRK_OCC, 8'h01 << t);
      trk_pattern(t);
      check_count(18, "occupancy");
    end
    $display("test tracker done");
  endtask : t_tracker

  task automatic t_undefined();
    logic [15:0] pairs [3] = '{16'h2103, 16'h5501, 16'h0808};
    for (int p = 0; p < 3; p++) begin
      select(pairs[p][15:8], pairs[p][7:0]);
      send_lookups();
      trk_pattern(0);
      check_count(0, "undefined pair");
    end
    $display("test undefined done");
  endtask : t_undefined

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_hit_miss();
    t_fill();
    t_victim();
    t_home();
    t_tracker();
    t_undefined();
    final_report();
  end

  // Cuts a hang short well inside the run budget
  initial begin
    repeat (60000) @(posedge pclk);
    fail("run timed out");
    final_report();
  end
endmodule : uncore_llc_home_event_select_bench
